// *** src/oms_mem.sv ***
// byte-wide memory with registered read data
module oms_mem #(
  parameter int aw = 11
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [aw-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] store [0:(1<<aw)-1];
  always_ff @(posedge clock) begin
    if (we) begin
      store[addr] <= wdata;
    end
    rdata <= store[addr];
  end
endmodule // oms_mem

// *** src/oms_params.svh ***
// constants for the on-chip memory select block
// What this block does
// - RAM answers byte/word in two states
// - RAM window per size variant decoded
// - enable bit zero disables, one enables RAM
// - enable bit set to one at reset
// - software standby leaves enable bit unchanged
// - expanded modes: disabled window goes external
// - single-chip, disabled: writes ignored, reads ff
// - ROM answers byte/word reads in two states
// - ROM disabled for mode 0,1; else enabled
// - ROM limit ef7f mode 2, f77f mode 3
// - mode pins, standby low, selects high: programming
// - programming mode suspends CPU memory access
// - program sub-mode decode: write, verify, inhibit
`ifndef OMS_PARAMS_SVH
`define OMS_PARAMS_SVH
`define OMS_REG_SYSCTL 4'h0
`define OMS_REG_STATUS 4'h4
`define OMS_REG_MEMCMD 4'h8
`define OMS_REG_MEMRD 4'hc
`define OMS_SYSCTL_RESET 8'h0b
`define OMS_SYSCTL_WMASK 8'hf5
`define OMS_RAM_EN_BIT 0
`define OMS_PIN_IDLE 14'h3ce0
`define OMS_RAM_LO_2K 16'hf780
`define OMS_RAM_LO_1K 16'hfb80
`define OMS_RAM_LO_512 16'hfd80
`define OMS_RAM_HI 16'hff7f
`define OMS_ROM_HI_M2 16'hef7f
`define OMS_ROM_HI_M3 16'hf77f
`define OMS_FILL 8'hff
`define OMS_RAM_AW 11
`define OMS_ROM_AW 16
`endif

// *** src/oms_pkg.sv ***
// types for the on-chip memory select block
package oms_pkg;
  typedef enum logic [3:0] {
    oms_idle = 4'b0001,
    oms_state1 = 4'b0010,
    oms_state2 = 4'b0100,
    oms_prog = 4'b1000
  } oms_state_type;
  typedef enum logic [1:0] {
    oms_var_2k = 2'h0,
    oms_var_1k = 2'h1,
    oms_var_512 = 2'h2
  } oms_variant_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } oms_cpu_req_type;
  typedef struct packed {
    logic to_ram;
    logic to_rom;
    logic to_ext;
    logic blank;
  } oms_route_type;
endpackage

// *** src/oms_top.sv ***
// on-chip RAM and ROM select, programming mode, register slave
`include "oms_params.svh"
module oms_top
  import oms_pkg::*;
#(
  parameter oms_variant_type variant = oms_var_2k
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic external_reset_pin_n,
  input wire logic soft_standby,
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic standby_pin_n,
  input wire logic prog_select_pin_a,
  input wire logic prog_select_pin_b,
  input wire logic prom_chip_select_n,
  input wire logic prom_output_enable_n,
  input wire logic prom_program_strobe_n,
  input wire logic [16:0] prom_address_lines,
  input wire logic [7:0] prom_data_in,
  output logic [7:0] prom_data_out,
  output logic prom_data_oe,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic cpu_word,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic cpu_done,
  output logic [15:0] cpu_rdata,
  output logic cpu_ext,
  output logic prog_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change counts when second and third agree
  localparam int npins = 14;
  localparam logic [npins-1:0] pin_idle = `OMS_PIN_IDLE;
  logic [npins-1:0] pin_raw;
  logic [npins-1:0] sync1;
  logic [npins-1:0] sync2;
  logic [npins-1:0] sync3;
  logic [npins-1:0] pin_q;
  assign pin_raw = {external_reset_pin_n, mode_pin_high, mode_pin_low, standby_pin_n,
                    prog_select_pin_a, prog_select_pin_b, prom_chip_select_n,
                    prom_output_enable_n, prom_program_strobe_n, soft_standby, 4'h0};
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1 <= pin_idle;
      sync2 <= pin_idle;
      sync3 <= pin_idle;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < npins; gi++) begin : g_pin
      always_ff @(posedge clock) begin
        if (rst) begin
          pin_q[gi] <= pin_idle[gi];
        end else if (sync2[gi] == sync3[gi]) begin
          pin_q[gi] <= sync3[gi];
        end
      end
    end
  endgenerate
  logic ext_reset_n_q, mode_high_q, mode_low_q, standby_n_q, sel_a_q, sel_b_q, ce_n_q, oe_n_q, strobe_n_q;
  assign {ext_reset_n_q, mode_high_q, mode_low_q, standby_n_q, sel_a_q, sel_b_q, ce_n_q, oe_n_q, strobe_n_q} =
         pin_q[13:5];
  logic ext_reset_n_d;
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_reset_n_d <= 1'b1;
    end else begin
      ext_reset_n_d <= ext_reset_n_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // decode functions
  function automatic logic ram_hit(input logic [15:0] a, input oms_variant_type v);
    logic [15:0] lo;
    lo = `OMS_RAM_LO_2K;
    case (v)
      oms_var_1k: lo = `OMS_RAM_LO_1K;
      oms_var_512: lo = `OMS_RAM_LO_512;
      default: lo = `OMS_RAM_LO_2K;
    endcase
    return (a >= lo) && (a <= `OMS_RAM_HI);
  endfunction
  function automatic logic rom_hit(input logic [15:0] a, input logic mh, input logic ml);
    logic en;
    en = mh;
    return en && (a <= (ml ? `OMS_ROM_HI_M3 : `OMS_ROM_HI_M2));
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // system control register
  logic [7:0] system_control;
  logic ram_enable_bit;
  logic wr_fire;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign ram_enable_bit = system_control[`OMS_RAM_EN_BIT];
  always_ff @(posedge clock) begin
    if (rst) begin
      system_control <= `OMS_SYSCTL_RESET;
    end else if (ext_reset_n_q && !ext_reset_n_d) begin
      system_control <= `OMS_SYSCTL_RESET;
    end else if (wr_fire && wr_addr[31:4] == '0 && wr_addr[3:0] == `OMS_REG_SYSCTL && wr_strb[0]) begin
      // standby entry/exit does not touch it
      system_control <= (system_control & ~`OMS_SYSCTL_WMASK) |
                        (wr_data[7:0] & `OMS_SYSCTL_WMASK);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // programming mode and sub-mode
  logic next_prog;
  logic prog_write;
  logic prog_verify;
  assign next_prog = !mode_high_q && !mode_low_q && !standby_n_q && sel_a_q && sel_b_q;
  assign prog_write = prog_mode && !ce_n_q && oe_n_q && !strobe_n_q;
  assign prog_verify = prog_mode && !ce_n_q && !oe_n_q && strobe_n_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      prog_mode <= 1'b0;
    end else begin
      prog_mode <= next_prog;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // routing
  oms_cpu_req_type req;
  oms_route_type route;
  logic single_chip;
  assign single_chip = mode_high_q && mode_low_q;
  always_comb begin
    route = '0;
    if (ram_hit(req.addr, variant)) begin
      route.to_ram = ram_enable_bit;
      route.blank = !ram_enable_bit && single_chip;
      route.to_ext = !ram_enable_bit && !single_chip;
    end else if (rom_hit(req.addr, mode_high_q, mode_low_q)) begin
      route.to_rom = 1'b1;
    end else begin
      route.to_ext = 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // cpu access sequencer: two states per access
  oms_state_type state;
  oms_state_type next_state;
  logic [15:0] rdata_hold;
  always_comb begin
    case (state)
      oms_idle: next_state = prog_mode ? oms_prog : (cpu_valid ? oms_state1 : oms_idle);
      oms_state1: next_state = oms_state2;
      oms_state2: next_state = oms_idle;
      oms_prog: next_state = prog_mode ? oms_prog : oms_idle;
      default: next_state = oms_idle;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= oms_idle;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      req <= '0;
    end else if (state == oms_idle && cpu_valid && !prog_mode) begin
      req <= '{1'b1, cpu_write, cpu_word, cpu_addr, cpu_wdata};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // memories: RAM as two byte lanes, ROM shared with programming pins
  logic [7:0] ram_q [2];
  logic [7:0] rom_q [2];
  logic rom_axi_we;
  logic [15:0] rom_axi_addr;
  logic [7:0] rom_axi_data;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lane
      logic lane_sel;
      logic [15:0] rom_a;
      logic rom_we;
      assign lane_sel = req.word || (req.addr[0] == 1'(gi));
      assign rom_a = prog_mode ? prom_address_lines[15:0] : (rom_axi_we ? rom_axi_addr :
                     {req.addr[15:1], 1'(gi)});
      assign rom_we = prog_mode ? (prog_write && prom_address_lines[0] == 1'(gi)) :
                      (rom_axi_we && rom_axi_addr[0] == 1'(gi));
      oms_mem #(.aw(`OMS_RAM_AW)) u_ram (
        .clock(clock),
        .we(state == oms_state1 && route.to_ram && req.write && lane_sel),
        .addr(req.addr[`OMS_RAM_AW-1:0] & ~`OMS_RAM_AW'(1) | `OMS_RAM_AW'(gi)),
        .wdata(gi == 0 ? req.wdata[7:0] : (req.word ? req.wdata[15:8] : req.wdata[7:0])),
        .rdata(ram_q[gi])
      );
      oms_mem #(.aw(`OMS_ROM_AW)) u_rom (
        .clock(clock),
        .we(rom_we),
        .addr({rom_a[15:1], 1'(gi)}),
        .wdata(prog_mode ? prom_data_in : rom_axi_data),
        .rdata(rom_q[gi])
      );
    end
  endgenerate
  always_comb begin
    if (route.to_ram) begin
      rdata_hold = {ram_q[1], ram_q[0]};
    end else if (route.to_rom) begin
      rdata_hold = {rom_q[1], rom_q[0]};
    end else begin
      rdata_hold = {`OMS_FILL, `OMS_FILL};
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_done <= 1'b0;
      cpu_rdata <= '0;
      cpu_ext <= 1'b0;
    end else begin
      cpu_done <= state == oms_state2;
      cpu_ext <= state == oms_state1 && route.to_ext;
      if (state == oms_state2) begin
        cpu_rdata <= req.word ? rdata_hold : (req.addr[0] ? {8'h00, rdata_hold[15:8]} :
                     {8'h00, rdata_hold[7:0]});
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      prom_data_out <= '0;
      prom_data_oe <= 1'b0;
    end else begin
      prom_data_oe <= prog_verify;
      prom_data_out <= prom_address_lines[0] ? rom_q[1] : rom_q[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: sysctl, status, rom load command, last cpu read
  logic aw_held, w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rom_axi_we = wr_fire && wr_addr[31:4] == '0 && wr_addr[3:0] == `OMS_REG_MEMCMD && wr_strb[0] && !prog_mode;
  assign rom_axi_addr = wr_data[31:16];
  assign rom_axi_data = wr_data[7:0];
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr[31:4] == '0 && wr_addr[3:0] != `OMS_REG_STATUS &&
                        wr_addr[3:0] != `OMS_REG_MEMRD && wr_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr[31:4] != '0) begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h2;
        end else begin
          case (s_axi_araddr[3:0])
            `OMS_REG_SYSCTL: s_axi_rdata <= {24'h0, system_control};
            `OMS_REG_STATUS: s_axi_rdata <= {24'h0, mode_high_q, mode_low_q, prog_mode, prog_write,
                                             prog_verify, ram_enable_bit, single_chip, 1'b0};
            `OMS_REG_MEMRD: s_axi_rdata <= {16'h0, cpu_rdata};
            default: begin
              s_axi_rdata <= '0;
              s_axi_rresp <= 2'h2;
            end
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // oms_top

// *** verification/oms_asserts.sv ***
// port assertions for the memory select block
module oms_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic prom_data_oe,
  input wire logic cpu_valid,
  input wire logic cpu_done,
  input wire logic cpu_ext,
  input wire logic prog_mode,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property (cpu_done |=> !cpu_done)
    else $error("cpu done held too long");
  a_done_latency: assert property (cpu_done |-> $past(cpu_valid, 3) || $past(cpu_valid, 4))
    else $error("cpu done without request two states before");
  a_ext_done: assert property (cpu_ext |-> ##1 cpu_done)
    else $error("external access not completed");
  a_prog_silent: assert property (prog_mode |-> !cpu_done && !cpu_ext)
    else $error("cpu access during programming");
  a_oe_prog: assert property (prom_data_oe |-> prog_mode)
    else $error("data pins driven outside programming");
  a_ext_mode3: assert property (cpu_ext |-> !(mode_pin_high && mode_pin_low))
    else $error("external access in single-chip mode");
  a_reset_quiet: assert property (@(posedge clock) disable iff (1'h0)
    rst |=> !cpu_done && !prog_mode && !prom_data_oe && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_ext: cover property (cpu_ext);
  c_verify: cover property (prog_mode && prom_data_oe);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // oms_asserts

// *** verification/oms_cpu_model.sv ***
// cpu core model issuing one memory request at a time
module oms_cpu_model
  import oms_pkg::*;
(
  input wire logic clock,
  input wire logic cpu_done,
  input wire logic cpu_ext,
  input wire logic [15:0] cpu_rdata,
  output oms_cpu_req_type req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // call just after a rising edge; valid lasts one cycle while idle
  task automatic access(input logic wr, wd, input logic [15:0] a, d, output logic [15:0] rd,
                        output logic got, ext);
    got = 1'h0;
    ext = 1'h0;
    req <= '{1'h1, wr, wd, a, d};
    @(posedge clock);
    req.valid <= 1'h0;
    for (int n = 0; n < 12 && !got; n++) begin
      @(posedge clock);
      ext |= cpu_ext === 1'h1;
      got = cpu_done === 1'h1;
    end
    rd = cpu_rdata;
  endtask
endmodule // oms_cpu_model

// *** verification/tb_top.sv ***
// self-checking bench for the memory select block
module tb_top
  import oms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0, rst = 1'h1, external_reset_pin_n = 1'h1, soft_standby = 1'h0, standby_pin_n = 1'h1;
  logic mode_pin_high = 1'h1, mode_pin_low = 1'h1, prog_select_pin_a = 1'h0, prog_select_pin_b = 1'h0;
  logic prom_chip_select_n = 1'h1, prom_output_enable_n = 1'h1, prom_program_strobe_n = 1'h1;
  logic [16:0] prom_address_lines = '0;
  logic [7:0] prom_data_in = '0, prom_data_out;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic prom_data_oe, cpu_done, cpu_ext, prog_mode, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [15:0] cpu_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  oms_cpu_req_type req;
  int n_mismatch = 0, num_checks = 0;
  oms_top #(.variant(oms_var_2k)) dut (.clock, .rst, .external_reset_pin_n, .soft_standby, .mode_pin_high,
    .mode_pin_low, .standby_pin_n, .prog_select_pin_a, .prog_select_pin_b, .prom_chip_select_n,
    .prom_output_enable_n, .prom_program_strobe_n, .prom_address_lines, .prom_data_in, .prom_data_out,
    .prom_data_oe, .cpu_valid(req.valid), .cpu_write(req.write), .cpu_word(req.word), .cpu_addr(req.addr),
    .cpu_wdata(req.wdata), .cpu_done, .cpu_rdata, .cpu_ext, .prog_mode, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  oms_cpu_model cpu_core (.clock, .cpu_done, .cpu_ext, .cpu_rdata, .req);
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stall(input string what);
    n_mismatch++;
    $display("[FAIL] %s expected answer seen none", what);
    give_verdict();
  endtask
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) stall("axi write");
    s_axi_bready <= 1'h0;
    check("write resp", 32'(er), 32'(s_axi_bresp));
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [31:0] a, exp, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) stall("axi read");
    s_axi_rready <= 1'h0;
    check("read resp", 32'(er), 32'(s_axi_rresp));
    check("read data", exp, s_axi_rdata);
    @(posedge clock);
  endtask
  task automatic cpu(input logic wr, wd, input logic [15:0] a, d, exp, input logic ee);
    logic [15:0] rd;
    logic got, ext;
    cpu_core.access(wr, wd, a, d, rd, got, ext);
    if (!got) stall("cpu access");
    check("cpu ext", 32'(ee), 32'(ext));
    if (!wr && !ee) check("cpu rdata", 32'(exp), 32'(rd));
  endtask
  task automatic mode(input logic h, l);
    mode_pin_high <= h;
    mode_pin_low <= l;
    repeat (8) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(32'h0, 32'h0b, 2'h0);
    axi_rd(32'h4, 32'hc6, 2'h0);
    axi_wr(32'h0, 32'h0, 2'h0);
    axi_rd(32'h0, 32'h0a, 2'h0);
    axi_wr(32'h4, 32'h0, 2'h2);
    axi_wr(32'h10, 32'h1, 2'h2);
    axi_rd(32'h10, 32'h0, 2'h2);
    axi_rd(32'h0, 32'h0a, 2'h0);
    axi_wr(32'h0, 32'h1, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_ram();
    cpu(1'h1, 1'h1, 16'hf780, 16'h1234, 16'h0, 1'h0);
    cpu(1'h0, 1'h1, 16'hf780, 16'h0, 16'h1234, 1'h0);
    cpu(1'h1, 1'h0, 16'hff7f, 16'h00a5, 16'h0, 1'h0);
    cpu(1'h0, 1'h0, 16'hff7f, 16'h0, 16'h00a5, 1'h0);
    axi_wr(32'h8, 32'hf77f003c, 2'h0);
    cpu(1'h0, 1'h0, 16'hf77f, 16'h0, 16'h003c, 1'h0);
    axi_rd(32'hc, 32'h003c, 2'h0);
    $display("test ram done");
  endtask
  task automatic t_off();
    axi_wr(32'h0, 32'h0, 2'h0);
    cpu(1'h1, 1'h1, 16'hf780, 16'h9999, 16'h0, 1'h0);
    cpu(1'h0, 1'h0, 16'hf780, 16'h0, 16'h00ff, 1'h0);
    cpu(1'h0, 1'h1, 16'hf780, 16'h0, 16'hffff, 1'h0);
    axi_wr(32'h0, 32'h1, 2'h0);
    cpu(1'h0, 1'h1, 16'hf780, 16'h0, 16'h1234, 1'h0);
    $display("test disabled ram done");
  endtask
  task automatic t_ext();
    axi_wr(32'h0, 32'h0, 2'h0);
    axi_wr(32'h8, 32'hef7f0077, 2'h0);
    mode(1'h1, 1'h0);
    cpu(1'h0, 1'h0, 16'hf780, 16'h0, 16'h0, 1'h1);
    cpu(1'h0, 1'h0, 16'hef7f, 16'h0, 16'h0077, 1'h0);
    cpu(1'h0, 1'h0, 16'hf77f, 16'h0, 16'h0, 1'h1);
    mode(1'h0, 1'h1);
    cpu(1'h0, 1'h0, 16'h0000, 16'h0, 16'h0, 1'h1);
    mode(1'h1, 1'h1);
    axi_wr(32'h0, 32'h1, 2'h0);
    $display("test expanded done");
  endtask
  task automatic t_standby();
    axi_wr(32'h0, 32'h0, 2'h0);
    soft_standby <= 1'h1;
    repeat (8) @(posedge clock);
    soft_standby <= 1'h0;
    repeat (8) @(posedge clock);
    axi_rd(32'h0, 32'h0a, 2'h0);
    external_reset_pin_n <= 1'h0;
    repeat (8) @(posedge clock);
    external_reset_pin_n <= 1'h1;
    repeat (8) @(posedge clock);
    axi_rd(32'h0, 32'h0b, 2'h0);
    $display("test standby done");
  endtask
  task automatic t_prog();
    logic [15:0] rd;
    logic got, ext;
    standby_pin_n <= 1'h0;
    prog_select_pin_a <= 1'h1;
    prog_select_pin_b <= 1'h1;
    mode(1'h0, 1'h0);
    check("prog mode", 32'h1, 32'(prog_mode));
    cpu_core.access(1'h0, 1'h0, 16'hf780, 16'h0, rd, got, ext);
    check("cpu in prog", 32'h0, 32'(got));
    prom_address_lines <= 17'h00010;
    prom_data_in <= 8'ha5;
    prom_chip_select_n <= 1'h0;
    prom_program_strobe_n <= 1'h0;
    repeat (10) @(posedge clock);
    prom_program_strobe_n <= 1'h1;
    repeat (10) @(posedge clock);
    prom_data_in <= 8'h5a;
    check("oe inhibit", 32'h0, 32'(prom_data_oe));
    prom_output_enable_n <= 1'h0;
    repeat (10) @(posedge clock);
    check("oe verify", 32'h1, 32'(prom_data_oe));
    check("verify data", 32'ha5, 32'(prom_data_out));
    prom_chip_select_n <= 1'h1;
    prom_output_enable_n <= 1'h1;
    standby_pin_n <= 1'h1;
    mode(1'h1, 1'h1);
    check("prog exit", 32'h0, 32'(prog_mode));
    $display("test programming done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    repeat (8) @(posedge clock);
    t_regs();
    t_ram();
    t_off();
    t_ext();
    t_standby();
    t_prog();
    give_verdict();
  end
endmodule // tb_top
bind oms_top oms_asserts chk (.clock, .rst, .mode_pin_high, .mode_pin_low, .prom_data_oe, .cpu_valid, .cpu_done,
  .cpu_ext, .prog_mode, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);
